// File: rtl/lnbp_pkg.sv
/*
  Constants and types for the local network bus pin port.
  Assumes one system clock and one link clock from the bus controller.
*/
package lnbp_pkg;

  // Link clock 49152 kHz at a frame rate of 48 kHz
  localparam int          LINK_CLK_KHZ  = 49152;
  localparam int          FRAME_RATE_HZ = 48000;

  localparam int          BYTE_W        = 8;
  localparam int          CNT_W         = 3;
  localparam logic [2:0]  CNT_ZERO      = 3'h0;
  localparam logic [2:0]  CNT_LAST      = 3'h7;
  localparam logic [2:0]  CNT_STEP      = 3'h1;

  // Output enables are active low
  localparam logic        PIN_RELEASED  = 1'h1;
  localparam logic        PIN_DRIVEN    = 1'h0;
  localparam logic        BIT_RESET     = 1'h0;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;

  typedef struct packed {
    logic [BYTE_W-1:0] dataByte;
    logic [BYTE_W-1:0] sigByte;
  } lnbp_word_type;

  localparam lnbp_word_type WORD_RESET = '{dataByte: 8'h00, sigByte: 8'h00};

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_SEND = 2'b01,
    LINK_DONE = 2'b10
  } lnbp_link_state_type;

endpackage : lnbp_pkg

// File: rtl/lnbp_pin_port.sv
/*
  Device-side pin port for a synchronous multi-drop local bus.
  Assumes the bus controller drives linkClk and keeps it running; the
  board resolves each shared line from its output and active-low enable.
*/
`timescale 1ns/100ps
module lnbp_pin_port
  import lnbp_pkg::*;
(
  // System side
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          mode5Pin,
  input  wire logic          txValid,
  input  wire lnbp_word_type txWord,
  output      logic          txReady,
  output      logic          rxValid,
  output      lnbp_word_type rxWord,
  // Link clock
  input  wire logic          linkClk,
  // Shared lines
  input  wire logic          sharedDataIn,
  output      logic          sharedDataOut,
  output      logic          sharedDataOeN,
  input  wire logic          sharedSignalIn,
  output      logic          sharedSignalOut,
  output      logic          sharedSignalOeN,
  // Dedicated output pins
  output      logic          dataOutputPin,
  output      logic          dataOutputOeN,
  output      logic          signalOutputPin,
  output      logic          signalOutputOeN
);

  ////////////////////////////////////////////////////////////////////////////
  // System domain

  lnbp_word_type txHold;
  logic          reqTgl;
  logic          ackSync1;
  logic          ackSync2;
  logic          ackSeen;
  logic          ackTgl;
  logic          rxTgl;
  logic          rxSync1;
  logic          rxSync2;
  logic          rxSeen;
  lnbp_word_type rxHold;

  // Word held stable until the link side acknowledges it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txHold  <= WORD_RESET;
      reqTgl  <= BIT_RESET;
      txReady <= 1'h1;
      ackSeen <= BIT_RESET;
    end else if (txValid && txReady) begin
      txHold  <= txWord;
      reqTgl  <= ~reqTgl;
      txReady <= 1'h0;
    end else if (ackSync2 != ackSeen) begin
      ackSeen <= ackSync2;
      txReady <= 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ackSync1 <= BIT_RESET;
      ackSync2 <= BIT_RESET;
      rxSync1  <= BIT_RESET;
      rxSync2  <= BIT_RESET;
    end else begin
      ackSync1 <= ackTgl;
      ackSync2 <= ackSync1;
      rxSync1  <= rxTgl;
      rxSync2  <= rxSync1;
    end
  end

  // rxHold stays stable for a whole byte time after its toggle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxSeen  <= BIT_RESET;
      rxValid <= BIT_RESET;
      rxWord  <= WORD_RESET;
    end else begin
      rxValid <= rxSync2 != rxSeen;
      if (rxSync2 != rxSeen) begin
        rxSeen <= rxSync2;
        rxWord <= rxHold;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain, clocked only by the controller's clock

  logic                linkRstSync1;
  logic                linkRstN;
  logic                modeSync1;
  logic                modeSync2;
  logic                reqSync1;
  logic                reqSync2;
  logic                reqSeen;
  lnbp_link_state_type state;
  logic [CNT_W-1:0]    txCnt;
  lnbp_word_type       txShift;
  logic                dataSample;
  logic                sigSample;
  logic [CNT_W-1:0]    rxCnt;
  lnbp_word_type       rxShift;

  always_ff @(posedge linkClk) begin
    linkRstSync1 <= rst_n;
    linkRstN     <= linkRstSync1;
  end

  always_ff @(posedge linkClk) begin
    if (!linkRstN) begin
      modeSync1 <= BIT_RESET;
      modeSync2 <= BIT_RESET;
      reqSync1  <= BIT_RESET;
      reqSync2  <= BIT_RESET;
    end else begin
      modeSync1 <= mode5Pin;
      modeSync2 <= modeSync1;
      reqSync1  <= reqTgl;
      reqSync2  <= reqSync1;
    end
  end

  // One byte on data and signal together, MSB first
  always_ff @(posedge linkClk) begin
    if (!linkRstN) begin
      state   <= LINK_IDLE;
      reqSeen <= BIT_RESET;
      txCnt   <= CNT_ZERO;
      txShift <= WORD_RESET;
      ackTgl  <= BIT_RESET;
    end else begin
      unique case (state)
        LINK_IDLE: begin
          if (reqSync2 != reqSeen) begin
            reqSeen <= reqSync2;
            txShift <= txHold;
            txCnt   <= CNT_ZERO;
            state   <= LINK_SEND;
          end
        end
        LINK_SEND: begin
          txShift.dataByte <= {txShift.dataByte[BYTE_W-2:0], BIT_RESET};
          txShift.sigByte  <= {txShift.sigByte[BYTE_W-2:0], BIT_RESET};
          txCnt            <= txCnt + CNT_STEP;
          if (txCnt == CNT_LAST) begin
            state <= LINK_DONE;
          end
        end
        LINK_DONE: begin
          ackTgl <= ~ackTgl;
          state  <= LINK_IDLE;
        end
        default: begin
          state <= LINK_IDLE;
        end
      endcase
    end
  end

  // Pin drivers; released unless a bit is being sent
  always_ff @(posedge linkClk) begin
    sharedDataOut   <= BIT_RESET;
    sharedSignalOut <= BIT_RESET;
    dataOutputPin   <= BIT_RESET;
    signalOutputPin <= BIT_RESET;
    sharedDataOeN   <= PIN_RELEASED;
    sharedSignalOeN <= PIN_RELEASED;
    dataOutputOeN   <= PIN_RELEASED;
    signalOutputOeN <= PIN_RELEASED;
    if (linkRstN && state == LINK_SEND) begin
      if (modeSync2) begin
        dataOutputPin   <= txShift.dataByte[BYTE_W-1];
        signalOutputPin <= txShift.sigByte[BYTE_W-1];
        dataOutputOeN   <= PIN_DRIVEN;
        signalOutputOeN <= PIN_DRIVEN;
      end else begin
        sharedDataOut   <= txShift.dataByte[BYTE_W-1];
        sharedSignalOut <= txShift.sigByte[BYTE_W-1];
        sharedDataOeN   <= PIN_DRIVEN;
        sharedSignalOeN <= PIN_DRIVEN;
      end
    end
  end

  // Receive whenever not transmitting; lines are synchronous to linkClk
  always_ff @(posedge linkClk) begin
    if (!linkRstN) begin
      dataSample <= BIT_RESET;
      sigSample  <= BIT_RESET;
      rxCnt      <= CNT_ZERO;
      rxShift    <= WORD_RESET;
      rxHold     <= WORD_RESET;
      rxTgl      <= BIT_RESET;
    end else begin
      dataSample <= sharedDataIn;
      sigSample  <= sharedSignalIn;
      if (state == LINK_IDLE && sharedDataOeN == PIN_RELEASED) begin
        rxShift.dataByte <= {rxShift.dataByte[BYTE_W-2:0], dataSample};
        rxShift.sigByte  <= {rxShift.sigByte[BYTE_W-2:0], sigSample};
        rxCnt            <= rxCnt + CNT_STEP;
        if (rxCnt == CNT_LAST) begin
          rxHold.dataByte <= {rxShift.dataByte[BYTE_W-2:0], dataSample};
          rxHold.sigByte  <= {rxShift.sigByte[BYTE_W-2:0], sigSample};
          rxTgl           <= ~rxTgl;
        end
      end else begin
        rxCnt <= CNT_ZERO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_reset_release: assert property (@(posedge linkClk)
    !linkRstN |=> sharedDataOeN && sharedSignalOeN && dataOutputOeN && signalOutputOeN)
    else $error("link pin driven after reset");

  a_five_no_shared: assert property (@(posedge linkClk) disable iff (!linkRstN)
    $past(modeSync2) |-> sharedDataOeN && sharedSignalOeN)
    else $error("shared line driven in five-pin mode");

  a_three_no_dedicated: assert property (@(posedge linkClk) disable iff (!linkRstN)
    !$past(modeSync2) |-> dataOutputOeN && signalOutputOeN)
    else $error("dedicated pin driven in three-pin mode");

  a_drive_only_send: assert property (@(posedge linkClk) disable iff (!linkRstN)
    !sharedDataOeN || !dataOutputOeN |-> $past(state) == LINK_SEND)
    else $error("data driven outside a send");

  a_signal_with_data: assert property (@(posedge linkClk) disable iff (!linkRstN)
    sharedSignalOeN == sharedDataOeN && signalOutputOeN == dataOutputOeN)
    else $error("signal and data enables differ");

  a_byte_length: assert property (@(posedge linkClk) disable iff (!linkRstN)
    $rose(state == LINK_SEND) |-> (state == LINK_SEND) [*8] ##1 state == LINK_DONE)
    else $error("send not eight bits long");

  a_ready_drop: assert property (@(posedge clk) disable iff (!rst_n)
    txValid && txReady |=> !txReady ##[1:70] txReady)
    else $error("transmit handshake wrong");

  c_send_three: cover property (@(posedge linkClk) disable iff (!linkRstN)
    !sharedDataOeN);
  c_send_five: cover property (@(posedge linkClk) disable iff (!linkRstN)
    !dataOutputOeN);
  c_receive: cover property (@(posedge clk) disable iff (!rst_n) rxValid);

endmodule : lnbp_pin_port

// File: dv/lnbp_ctrl_model.sv
/*
  Bus controller model: makes the link clock, drives the shared lines.
  Assumes the device releases its enables while it is silent.
*/
`timescale 1ns/100ps
module lnbp_ctrl_model (
  // Bench control
  input  wire logic       drive,
  input  wire logic [7:0] dataByte,
  input  wire logic [7:0] sigByte,
  // Link
  output      logic       linkClk,
  input  wire logic       devDataOut,
  input  wire logic       devDataOeN,
  input  wire logic       devSigOut,
  input  wire logic       devSigOeN,
  output      logic       dataLine,
  output      logic       sigLine
);
  logic [2:0] bitIdx = 3'h7;
  logic       junk   = 1'h0;
  initial begin
    linkClk = 1'h0;
    #3;
    forever #24 linkClk = ~linkClk;
  end
  // Released line toggles so a stale value never passes
  always @(posedge linkClk) begin
    bitIdx <= bitIdx - 3'h1;
    junk   <= ~junk;
  end
  assign dataLine = !devDataOeN ? devDataOut : (drive ? dataByte[bitIdx] : junk);
  assign sigLine  = !devSigOeN ? devSigOut : (drive ? sigByte[bitIdx] : junk);
endmodule : lnbp_ctrl_model

// File: dv/lnbp_pin_port_tb.sv
/*
  Bench for the pin port: reset state, sends in both modes, receive.
  Assumes the controller model makes the link clock.
*/
`timescale 1ns/100ps
module lnbp_pin_port_tb;
  import lnbp_pkg::*;
  logic clk, rst_n, mode5Pin, txValid, txReady, rxValid, drive;
  lnbp_word_type txWord, rxWord;
  logic linkClk, dIn, dOut, dOeN, sIn, sOut, sOeN, doPin, doOeN, soPin, soOeN;
  logic [7:0] shD, shS, dpD, dpS;
  int nSh, nDp, fail_count, n_checks;

  lnbp_pin_port lnbp_pin_port_inst (.clk(clk), .rst_n(rst_n), .mode5Pin(mode5Pin),
    .txValid(txValid), .txWord(txWord), .txReady(txReady), .rxValid(rxValid),
    .rxWord(rxWord), .linkClk(linkClk), .sharedDataIn(dIn), .sharedDataOut(dOut),
    .sharedDataOeN(dOeN), .sharedSignalIn(sIn), .sharedSignalOut(sOut),
    .sharedSignalOeN(sOeN), .dataOutputPin(doPin), .dataOutputOeN(doOeN),
    .signalOutputPin(soPin), .signalOutputOeN(soOeN));
  lnbp_ctrl_model lnbp_ctrl_model_inst (.drive(drive), .dataByte(8'hff), .sigByte(8'h00),
    .linkClk(linkClk), .devDataOut(dOut), .devDataOeN(dOeN), .devSigOut(sOut),
    .devSigOeN(sOeN), .dataLine(dIn), .sigLine(sIn));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Sample mid link cycle, away from the launching edge
  always @(negedge linkClk) begin
    if (!dOeN) begin
      shD = {shD[6:0], dOut};
      shS = {shS[6:0], sOut};
      nSh++;
    end
    if (!doOeN) begin
      dpD = {dpD[6:0], doPin};
      dpS = {dpS[6:0], soPin};
      nDp++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic send(input logic m5, input lnbp_word_type w);
    int i;
    @(negedge clk);
    mode5Pin = m5;
    repeat (20) @(negedge clk);
    nSh = 0;
    nDp = 0;
    txValid = 1'h1;
    txWord = w;
    @(negedge clk);
    txValid = 1'h0;
    for (i = 0; i < 300 && txReady !== 1'h1; i++) @(negedge clk);
    check("txReady", {15'h0, txReady}, 16'h0001);
    if (m5) begin
      check("dedicated bits", {dpD, dpS}, w);
      check("driven counts", {nSh[7:0], nDp[7:0]}, 16'h0008);
    end else begin
      check("shared bits", {shD, shS}, w);
      check("driven counts", {nSh[7:0], nDp[7:0]}, 16'h0800);
    end
    check("idle enables", {12'h0, dOeN, sOeN, doOeN, soOeN}, 16'h000f);
    $display("send test mode5Pin=%0d done", m5);
  endtask : send

  task automatic rx_test;
    int i;
    int n;
    n = 0;
    drive = 1'h1;
    for (i = 0; i < 400 && n < 3; i++) begin
      @(negedge clk);
      if (rxValid === 1'h1) n++;
    end
    check("rx bytes", n[15:0], 16'h0003);
    check("rxWord", rxWord, 16'hff00);
    drive = 1'h0;
    $display("receive test done");
  endtask : rx_test

  // Link side sees reset two of its edges late, through its synchroniser
  task automatic reset_test;
    rst_n = 1'h0;
    repeat (8) @(negedge clk);
    check("reset enables", {12'h0, dOeN, sOeN, doOeN, soOeN}, 16'h000f);
    rst_n = 1'h1;
    $display("reset test done");
  endtask : reset_test

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    mode5Pin = 1'h0;
    txValid = 1'h0;
    txWord = WORD_RESET;
    drive = 1'h0;
    fail_count = 0;
    n_checks = 0;
    reset_test();
    send(1'h0, 16'ha53c);
    send(1'h1, 16'h96c3);
    rx_test();
    tally_and_finish();
  end
endmodule : lnbp_pin_port_tb
